// ---- src/cmso_exec.sv ----
// Execution slice: products, negate, normalize, logic and stack ops
// Function
// - Escaped signed word product, two operands, 29 states
// - Escaped signed word product, three operands, 30 states
// - Signed byte product, two operands, 21 states
// - Signed byte product, three operands, 22 states
// - Unsigned word product, two operands, 25 states
// - Unsigned word product, three operands, 26 states
// - Unsigned byte product, two operands, 17 states
// - Unsigned byte product, three operands, 18 states
// - Products keep arithmetic and trap flags unchanged
// - Negate in 4 states, trap only sets
// - Idle does nothing for 4 states
// - Normalize shifts left, at most 31, count
// - Normalize 8 plus shifts, carry cleared
// - Invert operand in 4 states, clear carry
// - Union writes OR, clears carry and overflow
// - Pop copies top then stack pointer plus 2
// - Flags restore from stack, blocks next interrupt
// - Push decrements pointer by 2, stores operand
// - Flags save, clear word, block next interrupt
// - Subroutine exit loads counter, pointer plus 2
`timescale 1ns/1ps
module cmso_exec import cmso_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Core side status
	output logic busy,
	output logic irq_block
);
	// Byte-lane write merge
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : lane_merge

	// Byte-lane merge for the 16-bit registers; upper lanes are dropped
	function automatic logic [15:0] half_merge(input logic [15:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = lane_merge({16'h0000, old}, nw, sel);
		return r[15:0];
	endfunction : half_merge

	// Word product, sign extension chosen by sgn
	function automatic logic [31:0] word_prod(input logic [15:0] x, input logic [15:0] y,
		input logic sgn);
		logic [31:0] ex;
		logic [31:0] ey;
		ex = {{16{sgn & x[15]}}, x};
		ey = {{16{sgn & y[15]}}, y};
		return ex * ey;
	endfunction : word_prod

	// Byte product, sign extension chosen by sgn
	function automatic logic [15:0] byte_prod(input logic [7:0] x, input logic [7:0] y,
		input logic sgn);
		logic [15:0] ex;
		logic [15:0] ey;
		ex = {{8{sgn & x[7]}}, x};
		ey = {{8{sgn & y[7]}}, y};
		return ex * ey;
	endfunction : byte_prod

	// Leading zeros, saturating at 31
	function automatic logic [4:0] lead_zeros(input logic [31:0] v);
		logic [4:0] n;
		logic hit;
		n = 5'h00;
		hit = 1'b0;
		for (int i = 31; i > 0; i--) begin
			if (!hit && !v[i]) begin
				n = n + 5'h01;
			end else begin
				hit = 1'b1;
			end
		end
		return n;
	endfunction : lead_zeros

	// Opcode decode; escape byte selects the signed products
	function automatic cmso_kind_e decode_kind(input logic [7:0] b0, input logic [7:0] b1);
		cmso_kind_e k;
		k = K_NONE;
		if (b0 == OP_ESCAPE) begin
			case (b1[7:2])
				PFX_WPROD2: k = K_SWP2;
				PFX_WPROD3: k = K_SWP3;
				PFX_BPROD2: k = K_SBP2;
				PFX_BPROD3: k = K_SBP3;
				default: k = K_NONE;
			endcase
		end else begin
			case (b0)
				OP_TWOS_W: k = K_TWOS_W;
				OP_TWOS_B: k = K_TWOS_B;
				OP_IDLE: k = K_IDLE;
				OP_NORMALIZE: k = K_NORM;
				OP_INVERT_W: k = K_INV_W;
				OP_INVERT_B: k = K_INV_B;
				OP_FLAGS_RESTORE: k = K_FREST;
				OP_FLAGS_SAVE: k = K_FSAVE;
				OP_EXIT: k = K_EXIT;
				default: begin
					case (b0[7:2])
						PFX_WPROD2: k = K_UWP2;
						PFX_WPROD3: k = K_UWP3;
						PFX_BPROD2: k = K_UBP2;
						PFX_BPROD3: k = K_UBP3;
						PFX_UNION_W: k = K_UNION_W;
						PFX_UNION_B: k = K_UNION_B;
						PFX_POP: k = K_POP;
						PFX_PUSH: k = K_PUSH;
						default: k = K_NONE;
					endcase
				end
			endcase
		end
		return k;
	endfunction : decode_kind

	// Software-visible registers
	logic [15:0] opcode;
	logic [31:0] oper_a;
	logic [15:0] oper_b;
	logic [15:0] oper_c;
	logic [15:0] status_word;
	logic [15:0] stack_ptr;
	logic [15:0] prog_cnt;
	logic [15:0] stack_in;
	logic [31:0] result;
	logic [7:0] result_aux;
	logic [15:0] stack_out;
	logic offchip;
	logic done;
	logic illegal;
	logic [7:0] last_states;
	logic [7:0] last_bytes;
	// Sequencer
	cmso_state_e state;
	cmso_kind_e run_kind;
	logic [7:0] count;
	// Next values at commit
	logic [31:0] next_result;
	logic [7:0] next_aux;
	logic [15:0] next_status;
	logic [15:0] next_sptr;
	logic [15:0] next_prog;
	logic [15:0] next_stack_out;

	// Bus decode
	wire bus_req = wb_cyc_i & wb_stb_i;
	wire bus_wr = bus_req & wb_we_i & wb_ack_o;
	wire [31:0] wr_word = wb_dat_i;
	wire go_wr = bus_wr & (wb_adr_i == REG_GO) & wb_sel_i[0] & wb_dat_i[0];

	// Instruction decode and timing
	cmso_kind_e dec_kind;
	assign dec_kind = decode_kind(opcode[7:0], opcode[15:8]);
	wire dec_escaped = (opcode[7:0] == OP_ESCAPE);
	wire [1:0] dec_mode = dec_escaped ? opcode[9:8] : opcode[1:0];
	wire [4:0] norm_shift = lead_zeros(oper_a);
	wire dec_has_mode = (dec_kind inside {K_SWP2, K_SWP3, K_SBP2, K_SBP3, K_UWP2,
		K_UWP3, K_UBP2, K_UBP3, K_UNION_W, K_UNION_B, K_POP, K_PUSH});
	// Mode adds extra states and bytes only for mode-field opcodes
	wire [7:0] mode_states = dec_has_mode ? EXTRA_ADDR_STATES[8*dec_mode +: 8] : 8'h00;
	wire [7:0] mode_bytes = dec_has_mode ? EXTRA_ADDR_BYTES[8*dec_mode +: 8] : 8'h00;
	logic [7:0] base_states;
	wire [7:0] total_states = base_states + mode_states;
	wire start_take = go_wr & (state == IDLE) & (dec_kind != K_NONE);

	// Base state count per instruction
	always_comb begin
		case (dec_kind)
			K_SWP2: base_states = CNT_SWP2;
			K_SWP3: base_states = CNT_SWP3;
			K_SBP2: base_states = CNT_SBP2;
			K_SBP3: base_states = CNT_SBP3;
			K_UWP2: base_states = CNT_UWP2;
			K_UWP3: base_states = CNT_UWP3;
			K_UBP2: base_states = CNT_UBP2;
			K_UBP3: base_states = CNT_UBP3;
			K_NORM: base_states = CNT_NORM + {3'h0, norm_shift};
			K_POP: base_states = offchip ? CNT_POP_OFF : CNT_POP_ON;
			K_FREST: base_states = offchip ? CNT_FREST_OFF : CNT_FREST_ON;
			K_PUSH, K_FSAVE: base_states = offchip ? CNT_PUSH_OFF : CNT_PUSH_ON;
			K_EXIT: base_states = offchip ? CNT_EXIT_OFF : CNT_EXIT_ON;
			default: base_states = CNT_SHORT;
		endcase
	end

	// Results at the last state; products leave every flag alone
	always_comb begin
		logic [15:0] w;
		logic [7:0] b;
		logic [31:0] sh;
		w = 16'h0000;
		b = 8'h00;
		sh = oper_a << norm_shift;
		next_result = result;
		next_aux = result_aux;
		next_status = status_word;
		next_sptr = stack_ptr;
		next_prog = prog_cnt;
		next_stack_out = stack_out;
		case (run_kind)
			K_SWP2: next_result = word_prod(oper_a[15:0], oper_c, 1'b1);
			K_SWP3: next_result = word_prod(oper_b, oper_c, 1'b1);
			K_SBP2: next_result = {16'h0000, byte_prod(oper_a[7:0], oper_c[7:0], 1'b1)};
			K_SBP3: next_result = {16'h0000, byte_prod(oper_b[7:0], oper_c[7:0], 1'b1)};
			K_UWP2: next_result = word_prod(oper_a[15:0], oper_c, 1'b0);
			K_UWP3: next_result = word_prod(oper_b, oper_c, 1'b0);
			K_UBP2: next_result = {16'h0000, byte_prod(oper_a[7:0], oper_c[7:0], 1'b0)};
			K_UBP3: next_result = {16'h0000, byte_prod(oper_b[7:0], oper_c[7:0], 1'b0)};
			K_TWOS_W: begin
				w = 16'h0000 - oper_a[15:0];
				next_result = {16'h0000, w};
				next_status[SW_ZERO] = (w == 16'h0000);
				next_status[SW_SIGN] = w[15];
				next_status[SW_CARRY] = (oper_a[15:0] == 16'h0000);
				next_status[SW_OVF] = (oper_a[15:0] == 16'h8000);
				next_status[SW_OVF_TRAP] = status_word[SW_OVF_TRAP] | (oper_a[15:0] == 16'h8000);
			end
			K_TWOS_B: begin
				b = 8'h00 - oper_a[7:0];
				next_result = {24'h000000, b};
				next_status[SW_ZERO] = (b == 8'h00);
				next_status[SW_SIGN] = b[7];
				next_status[SW_CARRY] = (oper_a[7:0] == 8'h00);
				next_status[SW_OVF] = (oper_a[7:0] == 8'h80);
				next_status[SW_OVF_TRAP] = status_word[SW_OVF_TRAP] | (oper_a[7:0] == 8'h80);
			end
			K_NORM: begin
				next_result = sh;
				next_aux = {3'h0, norm_shift};
				next_status[SW_ZERO] = ~sh[31];
				next_status[SW_SIGN] = sh[31];
				next_status[SW_CARRY] = 1'b0;
			end
			K_INV_W, K_UNION_W: begin
				w = (run_kind == K_INV_W) ? ~oper_a[15:0] : (oper_a[15:0] | oper_c);
				next_result = {16'h0000, w};
				next_status[SW_ZERO] = (w == 16'h0000);
				next_status[SW_SIGN] = w[15];
				next_status[SW_CARRY] = 1'b0;
				next_status[SW_OVF] = 1'b0;
			end
			K_INV_B, K_UNION_B: begin
				b = (run_kind == K_INV_B) ? ~oper_a[7:0] : (oper_a[7:0] | oper_c[7:0]);
				next_result = {24'h000000, b};
				next_status[SW_ZERO] = (b == 8'h00);
				next_status[SW_SIGN] = b[7];
				next_status[SW_CARRY] = 1'b0;
				next_status[SW_OVF] = 1'b0;
			end
			K_POP: begin
				next_result = {16'h0000, stack_in};
				next_sptr = stack_ptr + STACK_STEP;
			end
			K_FREST: begin
				next_status = stack_in;
				next_sptr = stack_ptr + STACK_STEP;
			end
			K_PUSH: begin
				next_sptr = stack_ptr - STACK_STEP;
				next_stack_out = oper_c;
			end
			K_FSAVE: begin
				next_sptr = stack_ptr - STACK_STEP;
				next_stack_out = status_word;
				next_status = RST_WORD;
			end
			K_EXIT: begin
				next_prog = stack_in;
				next_sptr = stack_ptr + STACK_STEP;
			end
			default: next_result = result;
		endcase
	end

	// Commit on the last counted state
	wire commit = (state == RUN) & (count == 8'h01);
	assign busy = (state == RUN);

	// Sequencer: one state per clock, idle between instructions
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state <= IDLE;
			count <= 8'h00;
			run_kind <= K_NONE;
		end else if (start_take) begin
			state <= RUN;
			count <= total_states;
			run_kind <= dec_kind;
		end else if (commit) begin
			state <= IDLE;
			count <= 8'h00;
		end else if (state == RUN) begin
			count <= count - 8'h01;
		end
	end

	// Register file; commit wins over a software write in the same cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			opcode <= 16'h0000;
			oper_a <= 32'h00000000;
			oper_b <= 16'h0000;
			oper_c <= 16'h0000;
			status_word <= RST_WORD;
			stack_ptr <= 16'h0000;
			prog_cnt <= 16'h0000;
			stack_in <= 16'h0000;
			offchip <= 1'b0;
		end else begin
			if (bus_wr) begin
				case (wb_adr_i)
					REG_OPCODE: opcode <= half_merge(opcode, wr_word, wb_sel_i);
					REG_OPER_A: oper_a <= lane_merge(oper_a, wr_word, wb_sel_i);
					REG_OPER_B: oper_b <= half_merge(oper_b, wr_word, wb_sel_i);
					REG_OPER_C: oper_c <= half_merge(oper_c, wr_word, wb_sel_i);
					REG_STATUS_WORD: status_word <= half_merge(status_word, wr_word, wb_sel_i);
					REG_STACK_PTR: stack_ptr <= half_merge(stack_ptr, wr_word, wb_sel_i);
					REG_PROG_CNT: prog_cnt <= half_merge(prog_cnt, wr_word, wb_sel_i);
					REG_STACK_IN: stack_in <= half_merge(stack_in, wr_word, wb_sel_i);
					REG_CONFIG: offchip <= wb_sel_i[0] ? wr_word[0] : offchip;
					default: offchip <= offchip;
				endcase
			end
			if (commit) begin
				status_word <= next_status;
				stack_ptr <= next_sptr;
				prog_cnt <= next_prog;
			end
		end
	end

	// Results and completion flags; set wins over the clear by a new start
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			result <= 32'h00000000;
			result_aux <= 8'h00;
			stack_out <= 16'h0000;
			done <= 1'b0;
			illegal <= 1'b0;
			irq_block <= 1'b0;
			last_states <= 8'h00;
			last_bytes <= 8'h00;
		end else begin
			if (go_wr) begin
				done <= 1'b0;
				illegal <= (state == IDLE) & (dec_kind == K_NONE);
			end
			if (start_take) begin
				irq_block <= 1'b0;
				last_states <= total_states;
				last_bytes <= mode_bytes;
			end
			if (commit) begin
				result <= next_result;
				result_aux <= next_aux;
				stack_out <= next_stack_out;
				done <= 1'b1;
				irq_block <= (run_kind == K_FREST) | (run_kind == K_FSAVE);
			end
		end
	end

	// Read mux; unmapped offsets read as zero
	wire [31:0] rd_word =
		(wb_adr_i == REG_OPCODE) ? {16'h0000, opcode} :
		(wb_adr_i == REG_OPER_A) ? oper_a :
		(wb_adr_i == REG_OPER_B) ? {16'h0000, oper_b} :
		(wb_adr_i == REG_OPER_C) ? {16'h0000, oper_c} :
		(wb_adr_i == REG_STATUS_WORD) ? {16'h0000, status_word} :
		(wb_adr_i == REG_STACK_PTR) ? {16'h0000, stack_ptr} :
		(wb_adr_i == REG_PROG_CNT) ? {16'h0000, prog_cnt} :
		(wb_adr_i == REG_STACK_IN) ? {16'h0000, stack_in} :
		(wb_adr_i == REG_RESULT) ? result :
		(wb_adr_i == REG_STACK_OUT) ? {16'h0000, stack_out} :
		(wb_adr_i == REG_CONFIG) ? {31'h00000000, offchip} :
		(wb_adr_i == REG_STATE) ? {8'h00, last_bytes, last_states,
			4'h0, illegal, irq_block, done, busy} :
		(wb_adr_i == REG_AUX) ? {24'h000000, result_aux} : 32'h00000000;

	// Registered ack: one wait state, dropped after one cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req & ~wb_ack_o;
			wb_dat_o <= rd_word;
		end
	end

	// Product commits leave arithmetic and trap flags intact
	prod_flags_a: assert property (@(posedge clock) disable iff (sys_rst)
		commit && (run_kind inside {K_SWP2, K_SWP3, K_SBP2, K_SBP3, K_UWP2, K_UWP3,
		K_UBP2, K_UBP3}) |=> $stable(status_word[7:3]))
		else $error("product changed a flag");
	signed_prod_a: assert property (@(posedge clock) disable iff (sys_rst)
		commit && run_kind == K_SWP2 |=>
		$signed(result) == $signed($past(oper_a[15:0])) * $signed($past(oper_c)))
		else $error("signed word product wrong");
	idle_time_a: assert property (@(posedge clock) disable iff (sys_rst)
		start_take && dec_kind == K_IDLE && $stable(status_word) |=>
		busy [*4] ##1 (!busy && $stable(status_word)))
		else $error("idle timing or flags wrong");
	trap_sticky_a: assert property (@(posedge clock) disable iff (sys_rst)
		commit && (run_kind inside {K_TWOS_W, K_TWOS_B}) && status_word[SW_OVF_TRAP] |=>
		status_word[SW_OVF_TRAP])
		else $error("negate cleared the trap flag");
	norm_count_a: assert property (@(posedge clock) disable iff (sys_rst)
		commit && run_kind == K_NORM |=> result_aux <= 8'd31 &&
		(result[31] || result_aux == 8'd31))
		else $error("normalize count out of range");
	pop_ptr_a: assert property (@(posedge clock) disable iff (sys_rst)
		commit && run_kind == K_POP |=> stack_ptr == $past(stack_ptr) + 16'h0002)
		else $error("pop pointer step wrong");
	push_ptr_a: assert property (@(posedge clock) disable iff (sys_rst)
		commit && run_kind == K_PUSH |=> stack_ptr == $past(stack_ptr) - 16'h0002 &&
		stack_out == $past(oper_c))
		else $error("push pointer or data wrong");
	save_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
		commit && run_kind == K_FSAVE |=> status_word == 16'h0000 && irq_block &&
		stack_out == $past(status_word))
		else $error("flags save wrong");
	invert_flags_a: assert property (@(posedge clock) disable iff (sys_rst)
		commit && run_kind == K_INV_W |=> !status_word[SW_CARRY] && !status_word[SW_OVF]
		&& result[15:0] == ~$past(oper_a[15:0]))
		else $error("invert result or flags wrong");
	exit_load_a: assert property (@(posedge clock) disable iff (sys_rst)
		commit && run_kind == K_EXIT |=> prog_cnt == $past(stack_in))
		else $error("exit counter load wrong");
endmodule : cmso_exec

// ---- src/cmso_pkg.sv ----
// Constants and types for the multiply, logic and stack execution slice
package cmso_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_OPCODE = 8'h00;
	localparam logic [7:0] REG_OPER_A = 8'h04;
	localparam logic [7:0] REG_OPER_B = 8'h08;
	localparam logic [7:0] REG_OPER_C = 8'h0C;
	localparam logic [7:0] REG_STATUS_WORD = 8'h10;
	localparam logic [7:0] REG_STACK_PTR = 8'h14;
	localparam logic [7:0] REG_PROG_CNT = 8'h18;
	localparam logic [7:0] REG_STACK_IN = 8'h1C;
	localparam logic [7:0] REG_RESULT = 8'h20;
	localparam logic [7:0] REG_STACK_OUT = 8'h24;
	localparam logic [7:0] REG_CONFIG = 8'h28;
	localparam logic [7:0] REG_STATE = 8'h2C;
	localparam logic [7:0] REG_GO = 8'h30;
	localparam logic [7:0] REG_AUX = 8'h34;
	// Whole opcode bytes
	localparam logic [7:0] OP_ESCAPE = 8'hFE;
	localparam logic [7:0] OP_TWOS_W = 8'h03;
	localparam logic [7:0] OP_TWOS_B = 8'h13;
	localparam logic [7:0] OP_IDLE = 8'hFD;
	localparam logic [7:0] OP_NORMALIZE = 8'h0F;
	localparam logic [7:0] OP_INVERT_W = 8'h02;
	localparam logic [7:0] OP_INVERT_B = 8'h12;
	localparam logic [7:0] OP_FLAGS_RESTORE = 8'hF3;
	localparam logic [7:0] OP_FLAGS_SAVE = 8'hF2;
	localparam logic [7:0] OP_EXIT = 8'hF0;
	// Six-bit prefixes of opcodes carrying a mode field
	localparam logic [5:0] PFX_WPROD2 = 6'h1B;
	localparam logic [5:0] PFX_WPROD3 = 6'h13;
	localparam logic [5:0] PFX_BPROD2 = 6'h1F;
	localparam logic [5:0] PFX_BPROD3 = 6'h17;
	localparam logic [5:0] PFX_UNION_W = 6'h20;
	localparam logic [5:0] PFX_UNION_B = 6'h24;
	localparam logic [5:0] PFX_POP = 6'h33;
	localparam logic [5:0] PFX_PUSH = 6'h32;
	// Base state counts, one state per clock
	localparam logic [7:0] CNT_SWP2 = 8'd29;
	localparam logic [7:0] CNT_SWP3 = 8'd30;
	localparam logic [7:0] CNT_SBP2 = 8'd21;
	localparam logic [7:0] CNT_SBP3 = 8'd22;
	localparam logic [7:0] CNT_UWP2 = 8'd25;
	localparam logic [7:0] CNT_UWP3 = 8'd26;
	localparam logic [7:0] CNT_UBP2 = 8'd17;
	localparam logic [7:0] CNT_UBP3 = 8'd18;
	localparam logic [7:0] CNT_SHORT = 8'd4;
	localparam logic [7:0] CNT_NORM = 8'd8;
	localparam logic [7:0] CNT_POP_ON = 8'd12;
	localparam logic [7:0] CNT_POP_OFF = 8'd14;
	localparam logic [7:0] CNT_FREST_ON = 8'd9;
	localparam logic [7:0] CNT_FREST_OFF = 8'd13;
	localparam logic [7:0] CNT_PUSH_ON = 8'd8;
	localparam logic [7:0] CNT_PUSH_OFF = 8'd12;
	localparam logic [7:0] CNT_EXIT_ON = 8'd12;
	localparam logic [7:0] CNT_EXIT_OFF = 8'd16;
	// Extra states and bytes per addressing mode 0..3
	localparam logic [31:0] EXTRA_ADDR_STATES = 32'h03020100;
	localparam logic [31:0] EXTRA_ADDR_BYTES = 32'h02010101;
	// Status word flag positions
	localparam int SW_ZERO = 7;
	localparam int SW_SIGN = 6;
	localparam int SW_CARRY = 5;
	localparam int SW_OVF = 4;
	localparam int SW_OVF_TRAP = 3;
	localparam int SW_RESIDUE = 2;
	// Misc
	localparam logic [15:0] STACK_STEP = 16'h0002;
	localparam logic [4:0] NORM_MAX = 5'd31;
	localparam logic [15:0] RST_WORD = 16'h0000;
	typedef enum {IDLE, RUN} cmso_state_e;
	typedef enum {K_NONE, K_SWP2, K_SWP3, K_SBP2, K_SBP3, K_UWP2, K_UWP3, K_UBP2,
		K_UBP3, K_TWOS_W, K_TWOS_B, K_IDLE, K_NORM, K_INV_W, K_INV_B, K_UNION_W,
		K_UNION_B, K_POP, K_FREST, K_PUSH, K_FSAVE, K_EXIT} cmso_kind_e;
endpackage : cmso_pkg

// ---- bench/testbench.sv ----
// Self-checking bench for the execution slice, driven over its register bus
`timescale 1ns/1ps
`define CHK(g, e) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("MISMATCH at %0t: got %h expected %h", $time, g, e); \
	end \
end
module testbench import cmso_pkg::*;;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic busy;
	logic irq_block;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] rdat;
	// Product table: opcode with mode field, states, product of A/B with C
	logic [15:0] mop [8] = '{16'h6CFE, 16'h4DFE, 16'h7EFE, 16'h5FFE,
		16'h006C, 16'h004D, 16'h007E, 16'h005F};
	logic [7:0] mst [8] = '{8'h1D, 8'h1F, 8'h17, 8'h19, 8'h19, 8'h1B, 8'h13, 8'h15};
	logic [31:0] mres [8] = '{32'hFFFFFFFA, 32'hFFFFFFF7, 32'h0000FFFA, 32'h0000FFF7,
		32'h0002FFFA, 32'h0002FFF7, 32'h000002FA, 32'h000002F7};

	cmso_exec u_cmso_exec (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy(busy),
		.irq_block(irq_block));

	// 200 MHz clock
	always #2.5 clock = ~clock;

	// Verdict in one place, reached by the sequence or by the cycle ceiling
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out

	// Ceiling far above the thousand or so cycles the sequence needs
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			close_out();
		end
	end

	// Classic cycle: request held until ack is sampled, then released
	task automatic wb_access(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do @(posedge clock); while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb_access

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb_access(1'b1, a, d, 4'hF);
	endtask : wr

	// Read and compare the masked word
	task automatic chk(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFFFFFF);
		wb_access(1'b0, a, 32'h0, 4'hF);
		`CHK(rdat & m, e)
	endtask : chk

	// Start one instruction and count the states it stays busy
	task automatic go(input logic [15:0] op, input logic [7:0] n);
		int c;
		c = 0;
		wr(REG_OPCODE, {16'h0000, op});
		wb_access(1'b1, REG_GO, 32'h1, 4'h1);
		for (int t = 0; t < 300; t++) begin
			@(posedge clock);
			if (busy === 1'b1) c++;
			else if (c > 0) break;
		end
		`CHK(c[7:0], n)
		chk(REG_STATE, {16'h0000, n, 8'h02}, 32'h0000FF03);
	endtask : go

	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		// Reset state
		chk(REG_STATUS_WORD, 32'h0);
		chk(REG_STATE, 32'h0);
		`CHK(irq_block, 1'b0)
		// Idle leaves every flag alone
		wr(REG_STATUS_WORD, 32'hFC);
		go(16'h00FD, 8'h04);
		chk(REG_STATUS_WORD, 32'hFC, 32'hFFFF);
		// Every product form, each mode field in turn, flags preset to one
		wr(REG_OPER_A, 32'hFFFE);
		wr(REG_OPER_B, 32'hFFFD);
		wr(REG_OPER_C, 32'h0003);
		for (int i = 0; i < 8; i++) begin
			go(mop[i], mst[i]);
			chk(REG_RESULT, mres[i]);
			chk(REG_STATE, {8'h00, (i % 4 == 3) ? 8'h02 : 8'h01, 16'h0}, 32'hFF0000);
			chk(REG_STATUS_WORD, 32'hF8, 32'hF8);
		end
		// Negate: most negative word overflows, zero byte carries, trap sticks
		wr(REG_STATUS_WORD, 32'h0);
		wr(REG_OPER_A, 32'h8000);
		go(16'h0003, 8'h04);
		chk(REG_RESULT, 32'h8000, 32'hFFFF);
		chk(REG_STATUS_WORD, 32'h58, 32'hFC);
		wr(REG_OPER_A, 32'h0);
		go(16'h0013, 8'h04);
		chk(REG_RESULT, 32'h0, 32'hFF);
		chk(REG_STATUS_WORD, 32'hA8, 32'hFC);
		// Invert with carry and overflow preset
		wr(REG_STATUS_WORD, 32'h38);
		wr(REG_OPER_A, 32'h00FF);
		go(16'h0002, 8'h04);
		chk(REG_RESULT, 32'hFF00, 32'hFFFF);
		chk(REG_STATUS_WORD, 32'h48, 32'hFC);
		wr(REG_OPER_A, 32'h00FF);
		go(16'h0012, 8'h04);
		chk(REG_RESULT, 32'h0, 32'hFF);
		chk(REG_STATUS_WORD, 32'h88, 32'hFC);
		// Union, word in mode 0 and byte in mode 3
		wr(REG_STATUS_WORD, 32'h30);
		wr(REG_OPER_A, 32'h0F00);
		wr(REG_OPER_C, 32'h00F0);
		go(16'h0080, 8'h04);
		chk(REG_RESULT, 32'h0FF0, 32'hFFFF);
		chk(REG_STATUS_WORD, 32'h0, 32'hFC);
		wr(REG_OPER_A, 32'h80);
		wr(REG_OPER_C, 32'h01);
		go(16'h0093, 8'h07);
		chk(REG_RESULT, 32'h81, 32'hFF);
		chk(REG_STATUS_WORD, 32'h40, 32'hFC);
		// Normalize: fifteen shifts, then the all-zero limit of 31
		wr(REG_STATUS_WORD, 32'h3C);
		wr(REG_OPER_A, 32'h00010000);
		go(16'h000F, 8'h17);
		chk(REG_RESULT, 32'h80000000);
		chk(REG_AUX, 32'h0F, 32'hFF);
		chk(REG_STATUS_WORD, 32'h5C, 32'hFC);
		wr(REG_OPER_A, 32'h0);
		go(16'h000F, 8'h27);
		chk(REG_RESULT, 32'h0);
		chk(REG_AUX, 32'h1F, 32'hFF);
		chk(REG_STATUS_WORD, 32'h9C, 32'hFC);
		// Pop on-chip then off-chip, push off-chip then on-chip
		wr(REG_STACK_PTR, 32'h0100);
		wr(REG_STACK_IN, 32'hBEEF);
		go(16'h00CC, 8'h0C);
		chk(REG_RESULT, 32'hBEEF, 32'hFFFF);
		chk(REG_STACK_PTR, 32'h0102, 32'hFFFF);
		chk(REG_STATUS_WORD, 32'h9C, 32'hFFFF);
		wr(REG_CONFIG, 32'h1);
		go(16'h00CD, 8'h0F);
		chk(REG_STACK_PTR, 32'h0104, 32'hFFFF);
		wr(REG_OPER_C, 32'h1234);
		go(16'h00CA, 8'h0E);
		chk(REG_STACK_OUT, 32'h1234, 32'hFFFF);
		chk(REG_STACK_PTR, 32'h0102, 32'hFFFF);
		wr(REG_CONFIG, 32'h0);
		go(16'h00C8, 8'h08);
		chk(REG_STACK_PTR, 32'h0100, 32'hFFFF);
		chk(REG_STATUS_WORD, 32'h9C, 32'hFFFF);
		// Flags restore and save, both holding off the next interrupt
		wr(REG_STACK_IN, 32'h00FC);
		go(16'h00F3, 8'h09);
		chk(REG_STATUS_WORD, 32'hFC, 32'hFFFF);
		chk(REG_STACK_PTR, 32'h0102, 32'hFFFF);
		`CHK(irq_block, 1'b1)
		wr(REG_CONFIG, 32'h1);
		go(16'h00F2, 8'h0C);
		chk(REG_STACK_OUT, 32'hFC, 32'hFFFF);
		chk(REG_STATUS_WORD, 32'h0, 32'hFFFF);
		chk(REG_STACK_PTR, 32'h0100, 32'hFFFF);
		`CHK(irq_block, 1'b1)
		// Subroutine exit, off-chip then on-chip
		wr(REG_STACK_IN, 32'h2468);
		go(16'h00F0, 8'h10);
		chk(REG_PROG_CNT, 32'h2468, 32'hFFFF);
		chk(REG_STACK_PTR, 32'h0102, 32'hFFFF);
		`CHK(irq_block, 1'b0)
		wr(REG_CONFIG, 32'h0);
		go(16'h00F0, 8'h0C);
		chk(REG_STACK_PTR, 32'h0104, 32'hFFFF);
		// Flags save on-chip, flags restore off-chip
		go(16'h00F2, 8'h08);
		chk(REG_STACK_PTR, 32'h0102, 32'hFFFF);
		wr(REG_CONFIG, 32'h1);
		go(16'h00F3, 8'h0D);
		chk(REG_STATUS_WORD, 32'h2468, 32'hFFFF);
		chk(REG_STACK_PTR, 32'h0104, 32'hFFFF);
		`CHK(irq_block, 1'b1)
		wr(REG_CONFIG, 32'h0);
		// Escape with no known second byte never starts
		wr(REG_OPCODE, 32'h00FE);
		wb_access(1'b1, REG_GO, 32'h1, 4'h1);
		repeat (3) @(posedge clock);
		`CHK(busy, 1'b0)
		chk(REG_STATE, 32'h08, 32'h09);
		// Unmapped and write-only places read as zero
		chk(8'h3C, 32'h0);
		chk(REG_GO, 32'h0);
		close_out();
	end
endmodule : testbench
